// >>> bench/bwr_button_model.sv
// Purpose: Push-button and pulled-up interrupt line facing the controller
// Assumes: start is a one-cycle request; hold_cycles counts clock cycles
// Notes:   A released button reads high through its pull-up
`timescale 1ns/1ps
module bwr_button_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Press request
    input  wire logic        start,
    input  wire logic [31:0] hold_cycles,
    output logic             busy,
    output logic             button_input_n,
    // Interrupt line
    input  wire logic        int_n_o,
    input  wire logic        int_n_oe,
    output logic [15:0]      n_pulses,
    output logic [15:0]      last_width
);
    logic [31:0] left_q;
    logic [15:0] width_q;
    logic        int_line;

    assign int_line       = int_n_oe ? int_n_o : 1'b1;
    assign button_input_n = ~busy;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busy   <= 1'b0;
            left_q <= 32'h0;
        end else if (start) begin
            busy   <= 1'b1;
            left_q <= hold_cycles;
        end else if (busy) begin
            left_q <= left_q - 32'h1;
            busy   <= (left_q > 32'h1);
        end
    end

    // A pulse is logged at its end, so its full width is known
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            width_q    <= 16'h0;
            n_pulses   <= 16'h0;
            last_width <= 16'h0;
        end else if (!int_line) begin
            width_q <= width_q + 16'h1;
        end else if (width_q != 16'h0) begin
            n_pulses   <= n_pulses + 16'h1;
            last_width <= width_q;
            width_q    <= 16'h0;
        end
    end
endmodule : bwr_button_model

// >>> bench/bwr_controller_test.sv
// Purpose: Self-checking bench for the button wake and reset controller
// Assumes: Shortened timebase of 2 cycles per tick, 8-cycle interrupt pulse
// Notes:   Adapter watchdog runs dominate the run time, ahead of the ship and long-press runs
`timescale 1ns/1ps
module bwr_controller_test;
    localparam int TK = 2;
    logic        clock        = 1'b0;
    logic        nrst         = 1'b0;
    logic [3:0]  reg_addr     = 4'h0;
    logic [7:0]  reg_wdata    = 8'h00;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic        input_supply = 1'b0;
    logic        i2c_activity = 1'b0;
    logic        startup_done = 1'b0;
    logic        startup_fault = 1'b0;
    logic        start        = 1'b0;
    logic [31:0] hold         = 32'h0;
    logic [31:0] rng_q        = 32'h60;
    logic [7:0]  reg_rdata, rd;
    logic        button_input_n, busy, int_n_o, int_n_oe;
    logic        system_rail_en, load_reg_en, always_on_en, ship_state;
    logic [15:0] n_pulses, last_width, base, w1;
    logic [1:0]  c;
    logic [3:0]  ua;
    int          miscompares  = 0;
    int          n_compared   = 0;

    always #12.5 clock = ~clock;

    bwr_controller #(.TICK_CYCLES(TK), .INT_CYCLES(8)) dut_u (.clock, .nrst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .button_input_n, .input_supply,
        .i2c_activity, .startup_done, .startup_fault, .system_rail_en, .load_reg_en,
        .always_on_en, .ship_state, .int_n_o, .int_n_oe);

    bwr_button_model bm_u (.clock, .nrst, .start, .hold_cycles(hold), .busy,
        .button_input_n, .int_n_o, .int_n_oe, .n_pulses, .last_width);

    function automatic logic [31:0] xs();
        logic [31:0] s;
        s = rng_q;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        rng_q = s;
        return s;
    endfunction : xs

    function automatic logic [15:0] w1_ticks(input logic [1:0] code);
        return (code == 2'h0) ? 16'h0032 : (code == 2'h1) ? 16'h0064 : 16'h01F4;
    endfunction : w1_ticks

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rdr

    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clock);
    endtask : ticks

    task automatic press(input int n);
        @(posedge clock);
        start <= 1'b1;
        hold  <= n * TK;
        base  = n_pulses;
        @(posedge clock);
        start <= 1'b0;
    endtask : press

    // Extra cycles let a pulse still running at release finish
    task automatic release_wait(input logic [15:0] exp);
        // Busy rises on the edge that ends the press call, so look one edge later
        @(posedge clock);
        for (int k = 0; k < 20000 && busy; k++) @(posedge clock);
        repeat (12) @(posedge clock);
        check(n_pulses - base, exp);
    endtask : release_wait

    task automatic print_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (98000) @(posedge clock);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        #1 check({system_rail_en, always_on_en, ship_state, load_reg_en, int_n_oe}, 5'h18);
        for (int a = 0; a < 5; a++) begin
            rdr(4'(a), rd);
            check(rd, 8'h00);
        end
        repeat (4) begin
            ua = 4'h5 + 4'(xs() % 11);
            wr(ua, 8'(xs()));
            rdr(ua, rd);
            check(rd, 8'h00);
        end
        startup_done  <= 1'b1;
        startup_fault <= 1'b1;
        press(60);
        release_wait(0);
        rdr(4'h2, rd);
        startup_fault <= 1'b0;
        c  = 2'(xs() % 3);
        w1 = w1_ticks(c);
        wr(4'h0, {6'h00, c});
        press(w1 + 3);
        release_wait(1);
        check(last_width, 16'h0008);
        rdr(4'h2, rd);
        check(rd, 8'h01);
        rdr(4'h2, rd);
        check(rd, 8'h00);
        press(w1 + 3);
        ticks(2);
        wr(4'h0, 8'h03);
        release_wait(1);
        wr(4'h0, {6'h00, c});
        press(w1 + 3);
        release_wait(0);
        rdr(4'h2, rd);
        wr(4'h3, 8'h01);
        press(w1 + 3);
        release_wait(0);
        wr(4'h3, 8'h00);
        ticks(10);
        check(n_pulses - base, 0);
        rdr(4'h2, rd);
        check(rd, 8'h01);
        press(w1 + 3);
        release_wait(1);
        rdr(4'h2, rd);
        wr(4'h1, 8'h01);
        press(4004);
        ticks(2000);
        wr(4'h1, 8'h02);
        release_wait(3);
        check({ship_state, system_rail_en, always_on_en}, 3'h4);
        rdr(4'h2, rd);
        check(rd, 8'h07);
        press(200);
        ticks(100);
        check({ship_state, system_rail_en, always_on_en}, 3'h5);
        release_wait(0);
        check({ship_state, system_rail_en, always_on_en}, 3'h4);
        wr(4'h1, 8'h22);
        press(1300);
        ticks(1100);
        check({ship_state, system_rail_en, load_reg_en}, 3'h3);
        release_wait(0);
        rdr(4'h2, rd);
        check(rd, 8'h00);
        wr(4'h1, 8'h24);
        press(4004);
        release_wait(3);
        check({ship_state, system_rail_en}, 2'h1);
        rdr(4'h2, rd);
        wr(4'h1, 8'h02);
        press(4004);
        release_wait(3);
        check(ship_state, 1);
        rdr(4'h2, rd);
        press(500);
        ticks(100);
        input_supply <= 1'b1;
        repeat (3) @(posedge clock);
        check({ship_state, system_rail_en}, 2'h1);
        release_wait(0);
        input_supply <= 1'b0;
        wr(4'h1, 8'h10);
        repeat (2) @(posedge clock);
        check({system_rail_en, always_on_en}, 2'h1);
        rdr(4'h4, rd);
        check(rd, 8'h03);
        rdr(4'h1, rd);
        check(rd, 8'h00);
        ticks(90);
        check(system_rail_en, 0);
        ticks(15);
        check(system_rail_en, 1);
        wr(4'h1, 8'h08);
        input_supply <= 1'b1;
        ticks(100);
        i2c_activity <= 1'b1;
        @(posedge clock);
        i2c_activity <= 1'b0;
        ticks(13950);
        check(system_rail_en, 1);
        input_supply <= 1'b0;
        ticks(2);
        input_supply <= 1'b1;
        ticks(13990);
        check(system_rail_en, 1);
        ticks(20);
        check(system_rail_en, 0);
        print_verdict();
    end
endmodule : bwr_controller_test

// >>> rtl/bwr_controller.sv
// Purpose: Button wake, long-press reset, ship state and adapter watchdog control
// Assumes: All inputs synchronous to clock; i2c_activity is a one-cycle pulse
// Notes:   Durations other than the interrupt pulse are counted in 1 ms ticks from one shared timebase
`timescale 1ns/1ps
module bwr_controller #(
    parameter int TICK_CYCLES = bwr_pkg::TICK_CYCLES,
    parameter int INT_CYCLES  = bwr_pkg::INT_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Button and system status
    input  wire logic       button_input_n,
    input  wire logic       input_supply,
    input  wire logic       i2c_activity,
    input  wire logic       startup_done,
    input  wire logic       startup_fault,
    // Power controls
    output logic            system_rail_en,
    output logic            load_reg_en,
    output logic            always_on_en,
    output logic            ship_state,
    // Interrupt pin
    output logic            int_n_o,
    output logic            int_n_oe
);
    localparam int TW = $clog2(TICK_CYCLES);

    if (TICK_CYCLES < 2) begin : g_chk
        $error("TICK_CYCLES must be at least 2");
    end

    bwr_pkg::bwr_state_type state_q;
    bwr_pkg::bwr_dur_type   dur_q;
    logic [TW-1:0] tick_cnt_q;
    logic          tick;
    logic [7:0]    bctrl_q;
    logic [7:0]    cctrl_q;
    logic [2:0]    mask_q;
    logic [2:0]    flags_q;
    logic [2:0]    set_ev;
    logic [2:0]    rd_clr;
    logic [15:0]   press_q;
    logic [15:0]   press_nxt;
    logic          low;
    logic          lockout_q;
    logic          sup_whole_q;
    logic          sup_prev_q;
    logic          int_ok_q;
    logic          soft_cyc;
    logic [13:0]   wd_cnt_q;
    logic          wd_armed_q;
    logic          wd_fire;
    logic [6:0]    off_cnt_q;
    logic          lp_fire;
    logic          hit_w1;
    logic          hit_w2;
    logic          hit_warn;
    logic          pulse_fire;
    logic          pulse_active;

    assign low       = !button_input_n;
    assign press_nxt = (press_q == 16'hFFFF) ? press_q : press_q + 16'h0001;

    // Shared 1 ms timebase
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

    // Press duration; release restarts every button timer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            press_q <= '0;
        end else if (!low) begin
            press_q <= '0;
        end else if (tick) begin
            press_q <= press_nxt;
        end
    end

    // Durations are captured only while released, so edits land on the next press
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dur_q <= '0;
        end else if (!low) begin
            dur_q.first_wake_timer   <= bwr_pkg::first_wake_timer_ms(bctrl_q[1:0]);
            dur_q.second_wake_timer   <= bwr_pkg::second_wake_timer_ms(bctrl_q[3:2]);
            dur_q.lpress  <= bwr_pkg::lpress_ms(bctrl_q[7:6]);
            dur_q.warn_at <= bwr_pkg::lpress_ms(bctrl_q[7:6])
                             - bwr_pkg::warn_ms(bctrl_q[5:4]);
        end
    end

    assign hit_w1   = low && tick && press_nxt == dur_q.first_wake_timer && press_q != press_nxt;
    assign hit_w2   = low && tick && press_nxt == dur_q.second_wake_timer && press_q != press_nxt;
    assign hit_warn = low && tick && press_nxt == dur_q.warn_at && press_q != press_nxt;

    // Events only in normal operation and never during a held-over press
    assign set_ev[bwr_pkg::FL_FIRST_WAKE_TIMER] = hit_w1 && state_q == bwr_pkg::ST_ACTIVE
                                       && !lockout_q;
    assign set_ev[bwr_pkg::FL_SECOND_WAKE_TIMER] = hit_w2 && state_q == bwr_pkg::ST_ACTIVE
                                       && !lockout_q;
    assign set_ev[bwr_pkg::FL_WARN]  = hit_warn && state_q == bwr_pkg::ST_ACTIVE
                                       && !lockout_q;
    assign lp_fire = low && tick && press_nxt == dur_q.lpress && press_q != press_nxt
                     && state_q == bwr_pkg::ST_ACTIVE && !lockout_q;

    // Lockout after a ship exit with the button still held
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lockout_q <= 1'b0;
        end else if (!low) begin
            lockout_q <= 1'b0;
        end else if (state_q != bwr_pkg::ST_ACTIVE) begin
            lockout_q <= 1'b1;
        end
    end

    // Supply present for the whole press
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sup_whole_q <= 1'b0;
        end else if (!low || !input_supply) begin
            sup_whole_q <= input_supply;
        end
    end

    // Adapter-connect watchdog
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sup_prev_q <= 1'b0;
            wd_armed_q <= 1'b0;
            wd_cnt_q   <= '0;
        end else begin
            sup_prev_q <= input_supply;
            if (!cctrl_q[bwr_pkg::CC_WD_EN] || i2c_activity || wd_fire || !input_supply) begin
                wd_armed_q <= 1'b0;
                wd_cnt_q   <= '0;
            end else if (input_supply && !sup_prev_q) begin
                wd_armed_q <= 1'b1;
                wd_cnt_q   <= '0;
            end else if (wd_armed_q && tick) begin
                wd_cnt_q <= wd_cnt_q + 14'h0001;
            end
        end
    end
    assign wd_fire = wd_armed_q && tick
                     && wd_cnt_q == 14'(bwr_pkg::WATCHDOG_MS - 1);

    // Power state machine
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q   <= bwr_pkg::ST_ACTIVE;
            off_cnt_q <= '0;
        end else begin
            unique case (state_q)
                bwr_pkg::ST_ACTIVE: begin
                    off_cnt_q <= '0;
                    if (soft_cyc || wd_fire) begin
                        state_q <= bwr_pkg::ST_CYCLE;
                    end else if (lp_fire) begin
                        if (cctrl_q[1]) begin
                            state_q <= bwr_pkg::ST_SHIP;
                        end else if (cctrl_q[1:0] == bwr_pkg::ACT_CYCLE
                                     && (!cctrl_q[bwr_pkg::CC_NEEDS_SUP] || sup_whole_q)) begin
                            state_q <= bwr_pkg::ST_CYCLE;
                        end
                    end
                end
                bwr_pkg::ST_SHIP: begin
                    if (input_supply) begin
                        state_q <= bwr_pkg::ST_ACTIVE;
                    end else if (low && !lockout_q) begin
                        state_q <= bwr_pkg::ST_SHIP_WAKE;
                    end
                end
                bwr_pkg::ST_SHIP_WAKE: begin
                    if (input_supply || hit_w2) begin
                        state_q <= bwr_pkg::ST_ACTIVE;
                    end else if (!low) begin
                        state_q <= bwr_pkg::ST_SHIP;
                    end
                end
                bwr_pkg::ST_CYCLE: begin
                    if (tick) begin
                        off_cnt_q <= off_cnt_q + 7'h01;
                    end
                    if (tick && off_cnt_q == 7'(bwr_pkg::CYCLE_OFF_MS - 1)) begin
                        state_q <= bwr_pkg::ST_ACTIVE;
                    end
                end
            endcase
        end
    end

    assign system_rail_en = (state_q == bwr_pkg::ST_ACTIVE);
    assign load_reg_en    = system_rail_en && cctrl_q[bwr_pkg::CC_LOAD_EN];
    assign always_on_en   = (state_q != bwr_pkg::ST_SHIP);
    assign ship_state     = (state_q == bwr_pkg::ST_SHIP) || (state_q == bwr_pkg::ST_SHIP_WAKE);

    // Register writes
    assign soft_cyc = reg_wr && reg_addr == bwr_pkg::ADDR_CHIP_CTRL
                      && reg_wdata[bwr_pkg::CC_SOFT_CYC];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bctrl_q <= bwr_pkg::BUTTON_CTRL_RST;
            cctrl_q <= bwr_pkg::CHIP_CTRL_RST;
            mask_q  <= bwr_pkg::MASK_RST;
        end else if (reg_wr) begin
            if (reg_addr == bwr_pkg::ADDR_BUTTON_CTRL) begin
                bctrl_q <= reg_wdata;
            end
            if (reg_addr == bwr_pkg::ADDR_CHIP_CTRL) begin
                // Soft cycle bit is a trigger and never stored
                cctrl_q <= reg_wdata & ~(8'h01 << bwr_pkg::CC_SOFT_CYC);
            end
            if (reg_addr == bwr_pkg::ADDR_MASK) begin
                mask_q <= reg_wdata[2:0];
            end
        end
    end

    // Flags clear on read of the bits returned; a same-cycle set wins
    assign rd_clr = (reg_rd && reg_addr == bwr_pkg::ADDR_FLAGS) ? flags_q : 3'h0;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~rd_clr) | set_ev;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                bwr_pkg::ADDR_BUTTON_CTRL: reg_rdata <= bctrl_q;
                bwr_pkg::ADDR_CHIP_CTRL:   reg_rdata <= cctrl_q;
                bwr_pkg::ADDR_FLAGS:       reg_rdata <= {5'h00, flags_q};
                bwr_pkg::ADDR_MASK:        reg_rdata <= {5'h00, mask_q};
                bwr_pkg::ADDR_STATUS:      reg_rdata <= {3'h0, input_supply, lockout_q,
                                                         low, state_q};
                default:                   reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Interrupts are enabled only after a clean start-up; a faulted start enables once startup_fault clears
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            int_ok_q <= 1'b0;
        end else if (startup_done && !startup_fault) begin
            int_ok_q <= 1'b1;
        end
    end

    // Only a fresh flag set that is unmasked fires; unmasking later fires nothing
    assign pulse_fire = int_ok_q && |(set_ev & ~flags_q & ~mask_q);

    bwr_int_pulse #(
        .CYCLES (INT_CYCLES)
    ) u_pulse (
        .clock  (clock),
        .nrst   (nrst),
        .fire   (pulse_fire),
        .active (pulse_active)
    );

    assign int_n_o  = 1'b0;
    assign int_n_oe = pulse_active;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    ship_rail_off_a: assert property (ship_state |-> !system_rail_en && !load_reg_en)
        else $error("rail powered in ship state");
    cycle_aon_a: assert property (state_q == bwr_pkg::ST_CYCLE |-> always_on_en)
        else $error("always-on dropped in power cycle");
    wd_idle_a: assert property (!cctrl_q[bwr_pkg::CC_WD_EN] |=> wd_cnt_q == '0 && !wd_armed_q)
        else $error("watchdog runs while disabled");
    flag_hold_a: assert property (flags_q[0] && rd_clr[0] == 1'b0 |=> flags_q[0])
        else $error("wake flag lost without read");
    mask_gate_a: assert property (pulse_fire |-> |(set_ev & ~mask_q))
        else $error("pulse from masked source");
    startup_gate_a: assert property (!int_ok_q |-> ##1 !int_n_oe)
        else $error("interrupt before start-up");
    lockout_quiet_a: assert property (lockout_q |-> set_ev == 3'h0 && !lp_fire)
        else $error("event during lockout");
    supply_exit_a: assert property (state_q == bwr_pkg::ST_SHIP_WAKE && input_supply
        |=> state_q == bwr_pkg::ST_ACTIVE) else $error("supply did not exit ship");
    ship_entry_a: assert property (lp_fire && cctrl_q[1] && !soft_cyc && !wd_fire
        |=> state_q == bwr_pkg::ST_SHIP) else $error("ship action missed");
    first_wake_a: assert property (set_ev[bwr_pkg::FL_FIRST_WAKE_TIMER] |=> flags_q[bwr_pkg::FL_FIRST_WAKE_TIMER])
        else $error("first wake flag not set");
    wake_exit_a: assert property (state_q == bwr_pkg::ST_SHIP_WAKE && hit_w2
        |=> state_q == bwr_pkg::ST_ACTIVE) else $error("ship exit missed");
    release_ship_a: assert property (state_q == bwr_pkg::ST_SHIP_WAKE && !low && !input_supply
        |=> state_q == bwr_pkg::ST_SHIP) else $error("early release left ship");
    wd_cycle_a: assert property (wd_fire && state_q == bwr_pkg::ST_ACTIVE
        |=> state_q == bwr_pkg::ST_CYCLE) else $error("watchdog cycle missed");
endmodule : bwr_controller

// >>> rtl/bwr_int_pulse.sv
// Purpose: Fixed-length low pulse timer for the open-drain interrupt pin
// Assumes: fire is a one-cycle pulse in the clock domain
// Notes:   A new fire during a pulse restarts the full length
`timescale 1ns/1ps
module bwr_int_pulse #(
    parameter int CYCLES = bwr_pkg::INT_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Trigger and pulse
    input  wire logic fire,
    output logic      active
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_q;

    if (CYCLES < 1) begin : g_chk
        $error("CYCLES must be at least 1");
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (fire) begin
            cnt_q <= W'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign active = (cnt_q != '0);

    pulse_len_a: assert property (@(posedge clock) disable iff (!nrst)
        fire |=> active && cnt_q == W'(CYCLES)) else $error("pulse not started");
endmodule : bwr_int_pulse

// >>> rtl/bwr_pkg.sv
// Purpose: Shared constants and types for the button wake and reset controller
// Assumes: 40 MHz clock; all durations but the interrupt pulse counted in 1 ms ticks
// Notes:   Register offsets are word indices on the plain register port
package bwr_pkg;
    localparam int CLK_HZ           = 40_000_000;
    localparam int TICK_US          = 1000;
    localparam int TICK_CYCLES      = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int INT_PULSE_US     = 128;
    localparam int INT_PULSE_CYCLES = (CLK_HZ / 1_000_000) * INT_PULSE_US;
    localparam int WATCHDOG_S       = 14;
    localparam int WATCHDOG_MS      = WATCHDOG_S * 1000;
    localparam int CYCLE_OFF_MS     = 100;

    // Register map
    localparam logic [3:0] ADDR_BUTTON_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CHIP_CTRL   = 4'h1;
    localparam logic [3:0] ADDR_FLAGS       = 4'h2;
    localparam logic [3:0] ADDR_MASK        = 4'h3;
    localparam logic [3:0] ADDR_STATUS      = 4'h4;
    localparam logic [7:0] BUTTON_CTRL_RST  = 8'h00;
    localparam logic [7:0] CHIP_CTRL_RST    = 8'h00;
    localparam logic [2:0] MASK_RST         = 3'h0;

    // Chip control fields
    localparam int CC_ACTION_LSB = 0;
    localparam int CC_NEEDS_SUP  = 2;
    localparam int CC_WD_EN      = 3;
    localparam int CC_SOFT_CYC   = 4;
    localparam int CC_LOAD_EN    = 5;
    // Flag bit positions
    localparam int FL_FIRST_WAKE_TIMER = 0;
    localparam int FL_SECOND_WAKE_TIMER = 1;
    localparam int FL_WARN  = 2;

    localparam logic [1:0] ACT_CYCLE = 2'h0;
    localparam logic [1:0] ACT_NONE  = 2'h1;

    typedef enum logic [1:0] {
        ST_ACTIVE    = 2'b00,
        ST_SHIP      = 2'b01,
        ST_SHIP_WAKE = 2'b10,
        ST_CYCLE     = 2'b11
    } bwr_state_type;

    typedef struct packed {
        logic [15:0] first_wake_timer;
        logic [15:0] second_wake_timer;
        logic [15:0] lpress;
        logic [15:0] warn_at;
    } bwr_dur_type;

    function automatic logic [15:0] first_wake_timer_ms(input logic [1:0] c);
        case (c)
            2'h0: first_wake_timer_ms = 16'h0032;
            2'h1: first_wake_timer_ms = 16'h0064;
            2'h2: first_wake_timer_ms = 16'h01F4;
            default: first_wake_timer_ms = 16'h03E8;
        endcase
    endfunction : first_wake_timer_ms

    function automatic logic [15:0] second_wake_timer_ms(input logic [1:0] c);
        case (c)
            2'h0: second_wake_timer_ms = 16'h03E8;
            2'h1: second_wake_timer_ms = 16'h05DC;
            2'h2: second_wake_timer_ms = 16'h07D0;
            default: second_wake_timer_ms = 16'h0BB8;
        endcase
    endfunction : second_wake_timer_ms

    function automatic logic [15:0] lpress_ms(input logic [1:0] c);
        case (c)
            2'h0: lpress_ms = 16'h0FA0;
            2'h1: lpress_ms = 16'h1F40;
            2'h2: lpress_ms = 16'h2710;
            default: lpress_ms = 16'h36B0;
        endcase
    endfunction : lpress_ms

    function automatic logic [15:0] warn_ms(input logic [1:0] c);
        case (c)
            2'h0: warn_ms = 16'h01F4;
            2'h1: warn_ms = 16'h03E8;
            2'h2: warn_ms = 16'h05DC;
            default: warn_ms = 16'h07D0;
        endcase
    endfunction : warn_ms
endpackage : bwr_pkg
